// [pkg/qtm_map.svh]
// qtm_map.svh: register indices, field positions, reset values and clock divisors
// assumes: included by bare name from the core only; definitions only
// What this block does
// - eight-bit up-counter advances on selected source
// - counters readable and writable at any time
// - pair registers reachable as one sixteen-bit word
// - wrap from ff to 00 sets wrap flag
// - counters zero on reset and standby
// - counter equal match A sets match A flag
// - output follows match A and select A
// - match registers eight bits, reset to ff
// - counter equal match B sets match B flag
// - odd capture mode blocks even match B flag
// - output follows match B and select B
// - capture edge copies counter, sets match B flag
// - control layout: enables, clear select, source select
// - control bit 7 gates match B request
// - control bit 6 gates match A request
// - control bit 5 gates wrap request
// - clear select: never, A, B/capture, capture only
// - odd capture-clear blocks even match B clear
// - source codes: off, div 8, 64, 8192
// - external clock rising, falling or both edges
// - source code 4 cascades the channel pair
// - even channel upper byte, odd lower byte
// - flag clears by zero write after read one
// - flags bit 4 of odd channel selects capture
`ifndef QTM_MAP_SVH
`define QTM_MAP_SVH

// register kind, low three address bits; address bits 4:3 pick the channel
`define QTM_REG_CONTROL   3'h0
`define QTM_REG_FLAGS     3'h1
`define QTM_REG_MATCH_A   3'h2
`define QTM_REG_MATCH_B   3'h3
`define QTM_REG_COUNTER   3'h4

// control fields
`define QTM_CTL_MB_IE     7
`define QTM_CTL_MA_IE     6
`define QTM_CTL_WRAP_IE   5
`define QTM_CTL_CLR_HI    4
`define QTM_CTL_CLR_LO    3
`define QTM_CTL_SRC_HI    2
`define QTM_CTL_SRC_LO    0

// flag fields
`define QTM_FLG_MB        7
`define QTM_FLG_MA        6
`define QTM_FLG_WRAP      5
`define QTM_FLG_CAPSEL    4
`define QTM_FLG_OB_HI     3
`define QTM_FLG_OB_LO     2
`define QTM_FLG_OA_HI     1
`define QTM_FLG_OA_LO     0

// reset values
`define QTM_RST_COUNTER   8'h00
`define QTM_RST_MATCH     8'hff
`define QTM_RST_CONTROL   8'h00
`define QTM_RST_FLAGS     8'h00
`define QTM_RST_FLAGS_CH2 8'h10

// count source codes
`define QTM_SRC_OFF       3'h0
`define QTM_SRC_DIV_SHORT 3'h1
`define QTM_SRC_DIV_MID   3'h2
`define QTM_SRC_DIV_LONG  3'h3
`define QTM_SRC_CASCADE   3'h4
`define QTM_SRC_EXT_RISE  3'h5
`define QTM_SRC_EXT_FALL  3'h6
`define QTM_SRC_EXT_BOTH  3'h7

// clear source codes
`define QTM_CLR_NEVER     2'h0
`define QTM_CLR_MATCH_A   2'h1
`define QTM_CLR_MATCH_B   2'h2
`define QTM_CLR_CAPTURE   2'h3

// output action codes
`define QTM_OUT_KEEP      2'h0
`define QTM_OUT_LOW       2'h1
`define QTM_OUT_HIGH      2'h2
`define QTM_OUT_TOGGLE    2'h3

// system clock divisors
`define QTM_DIV_SHORT     8
`define QTM_DIV_MID       64
`define QTM_DIV_LONG      8192

`endif

// [pkg/qtm_pkg.sv]
// qtm_pkg: types shared by the timer core and its bench
// assumes: nothing outside; constants live in qtm_map.svh
package qtm_pkg;

    typedef logic [7:0] qtm_byte_t;

    // one register bus request, sampled at the rising clock edge
    typedef struct packed {
        logic [4:0]  addr;  // [4:3] channel, [2:0] register kind
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
        logic        word;  // 1: channel pair as one 16-bit word
    } qtm_bus_s;

endpackage

// [design/qtm_core.sv]
// qtm_core: four-channel 8-bit timer with compare, capture and cascade
// assumes: one 10 MHz clock, async active-low reset, standby level from
// the same clock domain, external pins asynchronous to the clock
`timescale 1ns/1ps
`include "qtm_map.svh"

module qtm_core #(
    parameter int unsigned DIV_SHORT = `QTM_DIV_SHORT,
    parameter int unsigned DIV_MID   = `QTM_DIV_MID,
    parameter int unsigned DIV_LONG  = `QTM_DIV_LONG
) (
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    input  wire logic             i_standby,
    input  wire qtm_pkg::qtm_bus_s i_bus,
    input  wire logic [3:0]       i_ext_clock,
    input  wire logic [1:0]       i_capture_in,
    output logic      [15:0]      o_rdata,
    output logic      [3:0]       o_timer_out,
    output logic      [3:0]       o_match_a_irq,
    output logic      [3:0]       o_match_b_irq,
    output logic      [3:0]       o_wrap_irq
);

    // divisors must be powers of two, DIV_LONG the largest
    localparam int unsigned PW = $clog2(DIV_LONG);
    localparam logic [PW-1:0] M_SHORT = PW'(DIV_SHORT - 1);
    localparam logic [PW-1:0] M_MID   = PW'(DIV_MID - 1);
    localparam logic [PW-1:0] M_LONG  = PW'(DIV_LONG - 1);

    qtm_pkg::qtm_byte_t cnt_r [4];
    qtm_pkg::qtm_byte_t cora_r[4];
    qtm_pkg::qtm_byte_t corb_r[4];
    qtm_pkg::qtm_byte_t ctl_r [4];
    qtm_pkg::qtm_byte_t flg_r [4];
    logic [2:0]         seen_r[4];
    logic [3:0]         ma_prev_r;
    logic [3:0]         mb_prev_r;
    logic [PW-1:0]      presc_r;
    logic [5:0]         pin_s1_r;
    logic [5:0]         pin_s2_r;
    logic [5:0]         pin_s3_r;
    logic [5:0]         pin_f_r;

    logic [3:0]         hit;
    logic [2:0]         kind;
    logic [3:0]         wr_ctl, wr_flg, wr_ma, wr_mb, wr_cnt, rd_flg;
    logic [5:0]         pin_rise, pin_fall;
    logic               div_s, div_m, div_l;
    logic [3:0]         ma_lvl, mb_lvl, ma_evt, mb_evt;
    logic [3:0]         cap_mode, mb_blocked, cap_evt, mb_set;
    logic [3:0]         clr_tk, clr_cap, base, tick, wrap;
    logic [15:0]        rd_word;
    qtm_pkg::qtm_byte_t wr_lane[4];
    logic [3:0]         tout_nxt;

    // channels addressed by an access; a word access takes both of the pair
    function automatic logic [3:0] sel_chans(input logic [1:0] ch, input logic word);
        if (word) begin
            sel_chans = ch[1] ? 4'hc : 4'h3;
        end else begin
            sel_chans = 4'h1 << ch;
        end
    endfunction

    // byte lane of a channel: even upper, odd lower in a word access
    function automatic qtm_pkg::qtm_byte_t lane_in(input logic [15:0] d,
                                                  input logic odd, input logic word);
        lane_in = (word && !odd) ? d[15:8] : d[7:0];
    endfunction

    // new level of a timer output for one match event
    function automatic logic out_apply(input logic cur, input logic [1:0] code);
        case (code)
            `QTM_OUT_LOW:    out_apply = 1'b0;
            `QTM_OUT_HIGH:   out_apply = 1'b1;
            `QTM_OUT_TOGGLE: out_apply = ~cur;
            default:         out_apply = cur;
        endcase
    endfunction

    // bus decode: one strobe may reach one channel or a pair
    always_comb begin
        hit  = sel_chans(i_bus.addr[4:3], i_bus.word);
        kind = i_bus.addr[2:0];
        for (int c = 0; c < 4; c++) begin
            wr_ctl[c] = i_bus.wr && hit[c] && (kind == `QTM_REG_CONTROL);
            wr_flg[c] = i_bus.wr && hit[c] && (kind == `QTM_REG_FLAGS);
            wr_ma[c]  = i_bus.wr && hit[c] && (kind == `QTM_REG_MATCH_A);
            wr_mb[c]  = i_bus.wr && hit[c] && (kind == `QTM_REG_MATCH_B);
            wr_cnt[c] = i_bus.wr && hit[c] && (kind == `QTM_REG_COUNTER);
            rd_flg[c] = i_bus.rd && hit[c] && (kind == `QTM_REG_FLAGS);
            wr_lane[c] = lane_in(i_bus.wdata, c[0], i_bus.word);
        end
    end

    // pins: bits 3:0 external clocks, 5:4 capture inputs of channels 1 and 3
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_s3_r <= 6'h00;
            pin_f_r  <= 6'h00;
        end else begin
            pin_s1_r <= {i_capture_in, i_ext_clock};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            // a level is accepted only once two stages agree, so a glitch is dropped
            pin_f_r  <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
        end
    end

    // edges of the accepted pin levels
    assign pin_rise = pin_s2_r & pin_s3_r & ~pin_f_r;
    assign pin_fall = ~pin_s2_r & ~pin_s3_r & pin_f_r;

    // free prescaler; standby holds it at zero
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            presc_r <= '0;
        end else if (i_standby) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_r + PW'(1);
        end
    end

    // one pulse per divided period
    assign div_s = (presc_r & M_SHORT) == M_SHORT;
    assign div_m = (presc_r & M_MID) == M_MID;
    assign div_l = presc_r == M_LONG;

    // per channel: matches, capture, clear conditions and plain count sources
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            ma_lvl[c] = cnt_r[c] == cora_r[c];
            mb_lvl[c] = cnt_r[c] == corb_r[c];
            ma_evt[c] = ma_lvl[c] && !ma_prev_r[c];
            mb_evt[c] = mb_lvl[c] && !mb_prev_r[c];
            cap_mode[c]   = c[0] && flg_r[c][`QTM_FLG_CAPSEL];
            mb_blocked[c] = !c[0] && flg_r[c | 1][`QTM_FLG_CAPSEL];
            // capture edge chosen by the output B field of the odd channel
            cap_evt[c] = cap_mode[c]
                && ((flg_r[c][`QTM_FLG_OB_LO] && pin_rise[4 + (c >> 1)])
                 || (flg_r[c][`QTM_FLG_OB_HI] && pin_fall[4 + (c >> 1)]));
            mb_set[c] = (mb_evt[c] && !mb_blocked[c] && !cap_mode[c]) || cap_evt[c];
            // a match clears at the next count, giving a period of match + 1
            clr_tk[c] = ((ctl_r[c][`QTM_CTL_CLR_HI:`QTM_CTL_CLR_LO] == `QTM_CLR_MATCH_A)
                         && ma_lvl[c])
                     || ((ctl_r[c][`QTM_CTL_CLR_HI:`QTM_CTL_CLR_LO] == `QTM_CLR_MATCH_B)
                         && mb_lvl[c] && !cap_mode[c]
                         && !(!c[0] && ctl_r[c | 1][`QTM_CTL_CLR_HI:`QTM_CTL_CLR_LO]
                              == `QTM_CLR_CAPTURE));
            clr_cap[c] = cap_evt[c] && ctl_r[c][`QTM_CTL_CLR_HI];
            case (ctl_r[c][`QTM_CTL_SRC_HI:`QTM_CTL_SRC_LO])
                `QTM_SRC_DIV_SHORT: base[c] = div_s;
                `QTM_SRC_DIV_MID:   base[c] = div_m;
                `QTM_SRC_DIV_LONG:  base[c] = div_l;
                `QTM_SRC_EXT_RISE:  base[c] = pin_rise[c];
                `QTM_SRC_EXT_FALL:  base[c] = pin_fall[c];
                `QTM_SRC_EXT_BOTH:  base[c] = pin_rise[c] || pin_fall[c];
                default:            base[c] = 1'b0;
            endcase
        end
    end

    // cascade: odd counts even match A, even counts odd wrap
    // both in cascade leaves the even channel without a clock
    always_comb begin
        for (int p = 0; p < 4; p += 2) begin
            tick[p + 1] = (ctl_r[p + 1][`QTM_CTL_SRC_HI:`QTM_CTL_SRC_LO] == `QTM_SRC_CASCADE)
                        ? ma_evt[p] : base[p + 1];
            wrap[p + 1] = tick[p + 1] && (cnt_r[p + 1] == 8'hff) && !clr_tk[p + 1]
                        && !clr_cap[p + 1];
            tick[p] = (ctl_r[p][`QTM_CTL_SRC_HI:`QTM_CTL_SRC_LO] == `QTM_SRC_CASCADE)
                    ? wrap[p + 1] : base[p];
            wrap[p] = tick[p] && (cnt_r[p] == 8'hff) && !clr_tk[p];
        end
    end

    // counters: write beats capture clear, which beats counting
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 4; c++) cnt_r[c] <= `QTM_RST_COUNTER;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (i_standby) begin
                    cnt_r[c] <= `QTM_RST_COUNTER;
                end else if (wr_cnt[c]) begin
                    cnt_r[c] <= lane_in(i_bus.wdata, c[0], i_bus.word);
                end else if (clr_cap[c]) begin
                    cnt_r[c] <= `QTM_RST_COUNTER;
                end else if (tick[c]) begin
                    cnt_r[c] <= clr_tk[c] ? `QTM_RST_COUNTER : cnt_r[c] + 8'h01;
                end
            end
        end
    end

    // match registers; a capture wins over a bus write in the same cycle
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 4; c++) begin
                cora_r[c] <= `QTM_RST_MATCH;
                corb_r[c] <= `QTM_RST_MATCH;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (i_standby) begin
                    cora_r[c] <= `QTM_RST_MATCH;
                    corb_r[c] <= `QTM_RST_MATCH;
                end else begin
                    if (wr_ma[c]) cora_r[c] <= lane_in(i_bus.wdata, c[0], i_bus.word);
                    if (cap_evt[c]) begin
                        corb_r[c] <= cnt_r[c];
                    end else if (wr_mb[c]) begin
                        corb_r[c] <= lane_in(i_bus.wdata, c[0], i_bus.word);
                    end
                end
            end
        end
    end

    // previous match levels, so a held equality flags only once
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ma_prev_r <= 4'h0;
            mb_prev_r <= 4'h0;
        end else begin
            ma_prev_r <= ma_lvl;
            mb_prev_r <= mb_lvl;
        end
    end

    // control registers
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 4; c++) ctl_r[c] <= `QTM_RST_CONTROL;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (i_standby) begin
                    ctl_r[c] <= `QTM_RST_CONTROL;
                end else if (wr_ctl[c]) begin
                    ctl_r[c] <= lane_in(i_bus.wdata, c[0], i_bus.word);
                end
            end
        end
    end

    // flag registers: status bits set by hardware, set beats clear
    // bit 4 of channel 2 is fixed at one
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < 4; c++) begin
                flg_r[c]  <= (c == 2) ? `QTM_RST_FLAGS_CH2 : `QTM_RST_FLAGS;
                seen_r[c] <= 3'h0;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (i_standby) begin
                    flg_r[c]  <= (c == 2) ? `QTM_RST_FLAGS_CH2 : `QTM_RST_FLAGS;
                    seen_r[c] <= 3'h0;
                end else begin
                    // only a zero written to a flag already read as one clears it
                    flg_r[c][`QTM_FLG_MB:`QTM_FLG_WRAP] <=
                        {mb_set[c], ma_evt[c], wrap[c]}
                        | (flg_r[c][`QTM_FLG_MB:`QTM_FLG_WRAP]
                           & ~({3{wr_flg[c]}} & seen_r[c]
                               & ~wr_lane[c][`QTM_FLG_MB:`QTM_FLG_WRAP]));
                    if (wr_flg[c]) begin
                        flg_r[c][`QTM_FLG_CAPSEL:0] <= (c == 2)
                            ? {1'b1, wr_lane[c][3:0]}
                            : wr_lane[c][4:0];
                        seen_r[c] <= 3'h0;
                    end else if (rd_flg[c]) begin
                        seen_r[c] <= seen_r[c] | flg_r[c][`QTM_FLG_MB:`QTM_FLG_WRAP];
                    end
                end
            end
        end
    end

    // read mux: unmapped kinds and unselected lanes read zero
    always_comb begin
        rd_word = 16'h0000;
        for (int c = 0; c < 4; c++) begin
            qtm_pkg::qtm_byte_t v;
            v = 8'h00;
            if (kind == `QTM_REG_CONTROL) begin
                v = ctl_r[c];
            end else if (kind == `QTM_REG_FLAGS) begin
                v = flg_r[c];
            end else if (kind == `QTM_REG_MATCH_A) begin
                v = cora_r[c];
            end else if (kind == `QTM_REG_MATCH_B) begin
                v = corb_r[c];
            end else if (kind == `QTM_REG_COUNTER) begin
                v = cnt_r[c];
            end
            if (hit[c]) begin
                if (i_bus.word && !c[0]) begin
                    rd_word[15:8] = v;
                end else begin
                    rd_word[7:0] = v;
                end
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_bus.rd ? rd_word : 16'h0000;
        end
    end

    // next timer output levels: B is applied after A, so B wins a tie
    always_comb begin
        tout_nxt = o_timer_out;
        for (int c = 0; c < 4; c++) begin
            if (ma_evt[c]) begin
                tout_nxt[c] = out_apply(tout_nxt[c], flg_r[c][`QTM_FLG_OA_HI:`QTM_FLG_OA_LO]);
            end
            if (mb_evt[c] && !cap_mode[c] && !mb_blocked[c]) begin
                tout_nxt[c] = out_apply(tout_nxt[c], flg_r[c][`QTM_FLG_OB_HI:`QTM_FLG_OB_LO]);
            end
        end
    end

    // timer output flops; standby drops every output low
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_timer_out <= 4'h0;
        end else begin
            o_timer_out <= i_standby ? 4'h0 : tout_nxt;
        end
    end

    // requests held while flag and enable are both set
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_match_a_irq <= 4'h0;
            o_match_b_irq <= 4'h0;
            o_wrap_irq    <= 4'h0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                o_match_b_irq[c] <= flg_r[c][`QTM_FLG_MB] && ctl_r[c][`QTM_CTL_MB_IE];
                o_match_a_irq[c] <= flg_r[c][`QTM_FLG_MA] && ctl_r[c][`QTM_CTL_MA_IE];
                o_wrap_irq[c]    <= flg_r[c][`QTM_FLG_WRAP] && ctl_r[c][`QTM_CTL_WRAP_IE];
            end
        end
    end

    default clocking dcb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    a_wrap_sets_flag:
        assert property (wrap[1] && !i_standby |=> flg_r[1][`QTM_FLG_WRAP])
        else $error("wrap did not set the wrap flag");
    a_match_a_flag:
        assert property (ma_evt[0] && !i_standby |=> flg_r[0][`QTM_FLG_MA])
        else $error("match A did not set its flag");
    a_block_b_flag:
        assert property ($rose(flg_r[2][`QTM_FLG_MB]) |-> !$past(flg_r[3][`QTM_FLG_CAPSEL]))
        else $error("channel 2 match B flag set while channel 3 captures");
    a_standby_zero:
        assert property (i_standby |=> cnt_r[3] == 8'h00 && cora_r[3] == 8'hff)
        else $error("standby did not initialise counter and match");
    a_capture_copy:
        assert property (cap_evt[3] && !i_standby
                         |=> corb_r[3] == $past(cnt_r[3]) && flg_r[3][`QTM_FLG_MB])
        else $error("capture did not copy the counter");
    a_count_step:
        assert property (tick[0] && !clr_tk[0] && !wr_cnt[0] && !i_standby
                         |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
        else $error("counter did not step by one");
    a_clear_on_a:
        assert property (tick[0] && ma_lvl[0] && !wr_cnt[0] && !i_standby
                         && ctl_r[0][4:3] == `QTM_CLR_MATCH_A |=> cnt_r[0] == 8'h00)
        else $error("match A clear missed");
    a_irq_gate_b:
        assert property (o_match_b_irq[0] |-> $past(ctl_r[0][`QTM_CTL_MB_IE]))
        else $error("match B request without enable");
    a_flag_clear:
        assert property (flg_r[0][`QTM_FLG_MA] && !seen_r[0][1] && !ma_evt[0] && !i_standby
                         |=> flg_r[0][`QTM_FLG_MA])
        else $error("flag cleared without a prior read");
    a_cascade_tick:
        assert property (ctl_r[1][2:0] == `QTM_SRC_CASCADE && ma_evt[0] |-> tick[1])
        else $error("cascade missed a match A event");

endmodule

// [verif/qtm_pin_model.sv]
// qtm_pin_model: far side of the timer pins, external clocks and capture inputs
// assumes: bench commands arrive on i_clock; pins rest low between bursts
`timescale 1ns/1ps
module qtm_pin_model (
    input  wire logic       i_clock,
    input  wire logic       i_start,
    input  wire logic [3:0] i_mask,
    input  wire logic [7:0] i_toggles,
    input  wire logic [1:0] i_cap,
    output logic      [3:0] o_ext_clock,
    output logic      [1:0] o_capture_in,
    output logic            o_busy
);
    logic [7:0] left_r = 8'h00;
    logic [1:0] div_r  = 2'h0;
    logic [3:0] pin_r  = 4'h0;
    // edges four cycles apart so the pin synchroniser never merges two
    always_ff @(posedge i_clock) begin
        if (i_start) begin
            left_r <= i_toggles;
        end else if (left_r != 8'h00) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                left_r <= left_r - 8'h01;
                pin_r  <= pin_r ^ i_mask;
            end
        end
    end
    assign o_busy       = (left_r != 8'h00) | i_start;
    assign o_ext_clock  = pin_r;
    assign o_capture_in = i_cap;
endmodule

// [verif/tb.sv]
// tb: self-checking bench for the four-channel timer core
// assumes: short divisors 2/8/16; pin model drives the external pins
`timescale 1ns/1ps
module tb;
    logic              i_clock   = 1'b0;
    logic              i_rstn    = 1'b0;
    logic              i_standby = 1'b0;
    qtm_pkg::qtm_bus_s bus       = '0;
    logic [1:0]        cap       = 2'h0;
    logic              start     = 1'b0;
    logic [3:0]        mask      = 4'h0;
    logic [7:0]        tog       = 8'h00;
    logic              busy;
    logic [3:0]        ext_clk;
    logic [1:0]        cap_in;
    logic [15:0]       rdata;
    logic [15:0]       q;
    logic [3:0]        tout;
    logic [3:0]        ia;
    logic [3:0]        ib;
    logic [3:0]        iw;
    int                error_cnt       = 0;
    int                samples_checked = 0;

    initial forever #50 i_clock = ~i_clock;

    qtm_core #(.DIV_SHORT(2), .DIV_MID(8), .DIV_LONG(16)) dut (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_standby(i_standby), .i_bus(bus),
        .i_ext_clock(ext_clk), .i_capture_in(cap_in), .o_rdata(rdata),
        .o_timer_out(tout), .o_match_a_irq(ia), .o_match_b_irq(ib), .o_wrap_irq(iw));

    qtm_pin_model pins (.i_clock(i_clock), .i_start(start), .i_mask(mask),
        .i_toggles(tog), .i_cap(cap), .o_ext_clock(ext_clk), .o_capture_in(cap_in),
        .o_busy(busy));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe, released at the next edge
    task wr(input logic [4:0] a, input logic [15:0] d, input logic w);
        @(posedge i_clock);
        bus <= '{a, d, 1'b1, 1'b0, w};
        @(posedge i_clock);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [4:0] a, input logic w);
        @(posedge i_clock);
        bus <= '{a, 16'h0000, 1'b0, 1'b1, w};
        @(posedge i_clock);
        bus.rd <= 1'b0;
        #1 q = rdata;
    endtask

    task t_reset;
        logic [2:0] kind [4];
        logic [7:0] exp [4];
        kind = '{3'h4, 3'h2, 3'h3, 3'h0};
        exp  = '{8'h00, 8'hff, 8'hff, 8'h00};
        for (int c = 0; c < 16; c++) begin
            rd({c[3:2], kind[c%4]}, 1'b0);
            chk(q, {8'h00, exp[c%4]});
        end
        rd(5'h11, 1'b0);
        chk(q, 16'h0010); // channel 2 flags come up with bit 4 set
        rd(5'h05, 1'b0);
        chk(q, 16'h0000); // unmapped kind reads zero
    endtask

    task t_word;
        wr(5'h04, 16'h12a5, 1'b1);
        rd(5'h04, 1'b0);
        chk(q, 16'h0012);
        rd(5'h0c, 1'b0);
        chk(q, 16'h00a5);
        rd(5'h0c, 1'b1);
        chk(q, 16'h12a5);
    endtask

    task t_rate;
        logic [7:0] lo [3];
        lo = '{8'd31, 8'd7, 8'd3};
        for (int i = 0; i < 3; i++) begin
            wr(5'h14, 16'h0000, 1'b0);
            wr(5'h10, 16'(i + 1), 1'b0);
            repeat (64) @(posedge i_clock);
            wr(5'h10, 16'h0000, 1'b0);
            rd(5'h14, 1'b0);
            chk(16'(q[7:0] >= lo[i] && q[7:0] <= lo[i] + 8'd2), 16'h0001);
        end
    endtask

    task t_match_a;
        wr(5'h04, 16'h0000, 1'b0);
        wr(5'h02, 16'h0003, 1'b0);
        wr(5'h01, 16'h0002, 1'b0);
        wr(5'h00, 16'h0049, 1'b0);
        for (int i = 0; i < 300 && ia[0] !== 1'b1; i++) @(posedge i_clock);
        chk(16'(ia[0]), 16'h0001);
        chk(16'(tout[0]), 16'h0001);
        wr(5'h00, 16'h0048, 1'b0);
        rd(5'h04, 1'b0);
        chk(16'(q <= 16'h0003), 16'h0001);
        rd(5'h01, 1'b0);
        chk(q, 16'h0042);
        wr(5'h01, 16'h0002, 1'b0);
        rd(5'h01, 1'b0);
        chk(q, 16'h0002);
        chk(16'(ia[0]), 16'h0000);
        wr(5'h01, 16'h00e2, 1'b0);
        rd(5'h01, 1'b0);
        chk(q, 16'h0002);
    endtask

    task t_wrap;
        wr(5'h0c, 16'h00fd, 1'b0);
        wr(5'h08, 16'h0021, 1'b0);
        for (int i = 0; i < 300 && iw[1] !== 1'b1; i++) @(posedge i_clock);
        chk(16'(iw[1]), 16'h0001);
        chk(16'(ia[1]), 16'h0000);
        wr(5'h08, 16'h0020, 1'b0);
        rd(5'h09, 1'b0);
        chk(q, 16'h00e0);
    endtask

    task t_ext;
        logic [7:0] exp [3];
        exp = '{8'd3, 8'd3, 8'd6};
        for (int i = 0; i < 3; i++) begin
            wr(5'h14, 16'h0000, 1'b0);
            wr(5'h10, 16'(i + 5), 1'b0);
            @(posedge i_clock);
            start <= 1'b1;
            mask  <= 4'h4;
            tog   <= 8'd6;
            @(posedge i_clock);
            start <= 1'b0;
            for (int k = 0; k < 100 && busy; k++) @(posedge i_clock);
            repeat (6) @(posedge i_clock);
            wr(5'h10, 16'h0000, 1'b0);
            rd(5'h14, 1'b0);
            chk(q, {8'h00, exp[i]});
        end
    endtask

    task t_capture;
        wr(5'h1c, 16'h0042, 1'b0);
        wr(5'h19, 16'h0014, 1'b0);
        @(posedge i_clock);
        cap <= 2'h2;
        repeat (8) @(posedge i_clock);
        cap <= 2'h0;
        rd(5'h1b, 1'b0);
        chk(q, 16'h0042);
        rd(5'h19, 1'b0);
        chk(q, 16'h0094);
        wr(5'h13, 16'h0006, 1'b0);
        rd(5'h11, 1'b0);
        chk(q, 16'h0010);
        wr(5'h04, 16'h0077, 1'b0);
        wr(5'h03, 16'h0077, 1'b0);
        repeat (3) @(posedge i_clock);
        chk(16'(ib[0]), 16'h0000);
        rd(5'h01, 1'b0);
        chk(q, 16'h0082);
        wr(5'h00, 16'h00c8, 1'b0);
        repeat (3) @(posedge i_clock);
        chk(16'(ib[0]), 16'h0001);
    endtask

    // only the odd channel cascades; it counts the even channel's match A events
    task t_cascade;
        wr(5'h04, 16'h0000, 1'b1);
        wr(5'h08, 16'h0004, 1'b0);
        wr(5'h00, 16'h0009, 1'b0);
        repeat (80) @(posedge i_clock);
        wr(5'h00, 16'h0000, 1'b0);
        rd(5'h0c, 1'b0);
        chk(16'(q[7:0] >= 8'd9 && q[7:0] <= 8'd11), 16'h0001);
    endtask

    task t_standby;
        @(posedge i_clock);
        i_standby <= 1'b1;
        @(posedge i_clock);
        i_standby <= 1'b0;
        rd(5'h04, 1'b0);
        chk(q, 16'h0000);
        rd(5'h1b, 1'b0);
        chk(q, 16'h00ff);
        rd(5'h00, 1'b0);
        chk(q, 16'h0000);
        chk(16'(ib[0]), 16'h0000);
    endtask

    task wrap_up;
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge i_clock);
        error_cnt++;
        wrap_up;
    end

    initial begin
        repeat (6) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_reset;
        t_word;
        t_rate;
        t_match_a;
        t_wrap;
        t_ext;
        t_capture;
        t_cascade;
        t_standby;
        wrap_up;
    end
endmodule
